/* rst_pkg.sv */
package rst_pkg;
  localparam logic [7:0] chip_control_addr     = 8'h9f;
  localparam logic [7:0] auxiliary_one_addr    = 8'ha2;
  localparam logic [7:0] watchdog_control_addr = 8'haa;
  localparam logic [7:0] timed_access_addr     = 8'hc7;
  localparam logic [7:0] key_first             = 8'haa;
  localparam logic [7:0] key_second            = 8'h55;
  localparam int         soft_trig_bit         = 7;
  localparam int         boot_sel_bit          = 1;
  localparam int         soft_flag_bit         = 7;
  localparam int         wdt_flag_bit          = 3;
  localparam int         wdt_clear_bit         = 6;
  localparam int         option_boot_bit       = 7;
  localparam logic [15:0] reset_pc             = 16'h0000;
  localparam logic [7:0] reset_sp              = 8'h07;
  localparam logic [7:0] port_latch_reset      = 8'hff;
  localparam logic [7:0] option_word_default   = 8'hff;
  localparam logic [7:0] chip_control_wmask    = 8'h43;
  localparam logic [7:0] auxiliary_one_wmask   = 8'hed;
  localparam int         debug_hold_clocks     = 600;
  localparam int         wdt_count_w           = 12;
  localparam int         hold_count_w          = 10;

  typedef enum logic [1:0] {
    cause_none,
    cause_wdt,
    cause_soft,
    cause_ext
  } cause_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  port_latch;
    logic        ram_clear;
    logic        periph_en;
  } core_reset_t;
endpackage

/* sync2.sv */
`timescale 1ns/1ps
module sync2 (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;
  sync_t st_ff;
  sync_t nxt_st;
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.s2;
endmodule // sync2

/* wdt_counter.sv */
`timescale 1ns/1ps
module wdt_counter #(
  parameter int W = rst_pkg::wdt_count_w
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic              expire
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } wdt_t;
  wdt_t st_ff;
  wdt_t nxt_st;
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.exp = 1'b0;
    if (clr) begin
      nxt_st.cnt = '0; // [RULE2]
    end else if (tick) begin
      if (st_ff.cnt >= limit) begin
        nxt_st.exp = 1'b1;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign expire = st_ff.exp;
endmodule // wdt_counter

/* reset_source_and_boot_select.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Watchdog expiry resets system, PC 0000H
// [RULE2] Software clear restarts watchdog count
// [RULE3] Watchdog reset sets flag bit three
// [RULE4] Watchdog flag survives other resets, clearable
// [RULE5] Keyed write bit seven triggers reset
// [RULE6] Trigger instruction is last one executed
// [RULE7] Trigger bit write-only, self clearing
// [RULE8] Soft reset sets auxiliary flag bit
// [RULE9] Soft flag survives other resets, clearable
// [RULE10] Software disables interrupts, writes key pair
// [RULE11] Boot select picks application or loader
// [RULE12] Non-soft resets load inverted option choice
// [RULE13] Option choice one means application flash
// [RULE14] Boot decision uses register bit only
// [RULE15] RAM kept except after power-on
// [RULE16] PC held 0000H during reset
// [RULE17] Stack pointer returns to 07H
// [RULE18] Peripherals off, latches FFH, input-only
// [RULE19] Debug pins quasi for 600 slow clocks
// [RULE20] Divided clock: use wake-up timer instead
module reset_source_and_boot_select #(
  parameter int WDT_W     = rst_pkg::wdt_count_w,
  parameter int HOLD_CNT  = rst_pkg::debug_hold_clocks
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 ext_rst_pin,
  input  wire logic                 slow_osc_tick,
  input  wire logic [WDT_W-1:0]     wdt_limit,
  input  wire logic [7:0]           option_word_zero,
  input  wire rst_pkg::reg_req_t    req,
  input  wire logic                 global_irq_enable,
  output logic [7:0]                rdata,
  output logic                      sys_reset,
  output logic                      instr_block,
  output logic                      boot_from_loader,
  output rst_pkg::core_reset_t      core_rst,
  output logic                      debug_pins_quasi
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int hold_count_w_l = rst_pkg::hold_count_w;

  typedef enum logic [1:0] {
    st_run,
    st_assert,
    st_release
  } rst_state_t;

  typedef struct packed {
    rst_state_t           fsm;
    rst_pkg::cause_t      cause;
    logic                 por_done;
    logic                 key_step1;
    logic                 key_open;
    logic                 soft_trig;
    logic                 boot_sel;
    logic                 soft_flag;
    logic                 wdt_flag;
    logic [7:0]           chip_other;
    logic [7:0]           aux_other;
    logic [7:0]           wdc_other;
    logic [hold_count_w_l-1:0] hold_cnt;
    logic                 quasi;
    logic [7:0]           rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic   ext_sync;
  logic   wdt_expire;
  logic   wdt_clr;

  function automatic logic hit(input rst_pkg::reg_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  sync2 u_ext_sync (
    .mclk (mclk),
    .rstn (rstn),
    .din  (ext_rst_pin),
    .dout (ext_sync)
  );

  assign wdt_clr = hit(req, rst_pkg::watchdog_control_addr) && st_ff.key_open &&
                   req.wdata[rst_pkg::wdt_clear_bit]; // [RULE2]

  wdt_counter #(.W(WDT_W)) u_wdt (
    .mclk   (mclk),
    .rstn   (rstn),
    .tick   (slow_osc_tick),
    .clr    (wdt_clr || sys_reset),
    .limit  (wdt_limit),
    .expire (wdt_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencing, flags, registers
  always_comb begin
    logic soft_hit;
    soft_hit = 1'b0;
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    soft_hit = hit(req, rst_pkg::chip_control_addr) && st_ff.key_open &&
               req.wdata[rst_pkg::soft_trig_bit]; // [RULE5]
    // Key window: first byte then second, any other write closes it
    if (req.wr && req.addr == rst_pkg::timed_access_addr) begin
      nxt_st.key_step1 = (req.wdata == rst_pkg::key_first);
      nxt_st.key_open  = st_ff.key_step1 && (req.wdata == rst_pkg::key_second);
    end else if (req.wr) begin
      nxt_st.key_step1 = 1'b0;
      nxt_st.key_open  = 1'b0;
    end
    if (st_ff.fsm == st_run && !st_ff.key_open) begin
      // Unkeyed writes to ordinary bits
      if (hit(req, rst_pkg::chip_control_addr)) begin
        nxt_st.chip_other = req.wdata & rst_pkg::chip_control_wmask;
        nxt_st.boot_sel   = req.wdata[rst_pkg::boot_sel_bit];
      end
    end
    if (st_ff.key_open && hit(req, rst_pkg::chip_control_addr)) begin
      nxt_st.chip_other = req.wdata & rst_pkg::chip_control_wmask;
      nxt_st.boot_sel   = req.wdata[rst_pkg::boot_sel_bit];
      nxt_st.soft_trig  = req.wdata[rst_pkg::soft_trig_bit]; // [RULE5]
    end
    if (hit(req, rst_pkg::auxiliary_one_addr)) begin
      nxt_st.aux_other = req.wdata & rst_pkg::auxiliary_one_wmask;
      nxt_st.soft_flag = req.wdata[rst_pkg::soft_flag_bit]; // [RULE9]
    end
    if (hit(req, rst_pkg::watchdog_control_addr) && st_ff.key_open) begin
      nxt_st.wdc_other = req.wdata & 8'h37;
      nxt_st.wdt_flag  = req.wdata[rst_pkg::wdt_flag_bit]; // [RULE4]
    end
    if (req.rd) begin
      case (req.addr)
        rst_pkg::chip_control_addr: begin
          // Trigger bit reads back zero: write-only
          nxt_st.rdata = {1'b0, st_ff.chip_other[6:2], st_ff.boot_sel,
                          st_ff.chip_other[0]}; // [RULE7]
        end
        rst_pkg::auxiliary_one_addr: begin
          nxt_st.rdata = {st_ff.soft_flag, st_ff.aux_other[6:0]};
        end
        rst_pkg::watchdog_control_addr: begin
          nxt_st.rdata = {st_ff.wdc_other[7:4], st_ff.wdt_flag, st_ff.wdc_other[2:0]};
        end
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    case (st_ff.fsm)
      st_run: begin
        if (!st_ff.por_done) begin
          nxt_st.fsm   = st_assert;
          nxt_st.cause = rst_pkg::cause_none;
        end else if (wdt_expire) begin
          nxt_st.fsm   = st_assert; // [RULE1]
          nxt_st.cause = rst_pkg::cause_wdt;
        end else if (soft_hit) begin
          nxt_st.fsm   = st_assert; // [RULE6]
          nxt_st.cause = rst_pkg::cause_soft;
        end else if (ext_sync) begin
          nxt_st.fsm   = st_assert;
          nxt_st.cause = rst_pkg::cause_ext;
        end
      end
      st_assert: begin
        nxt_st.por_done  = 1'b1;
        nxt_st.key_step1 = 1'b0;
        nxt_st.key_open  = 1'b0;
        nxt_st.chip_other = 8'h00;
        nxt_st.aux_other  = 8'h00;
        nxt_st.wdc_other  = 8'h07;
        if (st_ff.cause == rst_pkg::cause_wdt) begin
          nxt_st.wdt_flag = 1'b1; // [RULE3]
        end
        if (st_ff.cause == rst_pkg::cause_soft) begin
          nxt_st.soft_flag = 1'b1; // [RULE8]
        end else begin
          // Option bit 1 = application, so invert into select
          nxt_st.boot_sel = ~option_word_zero[rst_pkg::option_boot_bit]; // [RULE12] [RULE13]
        end
        if (!(st_ff.cause == rst_pkg::cause_ext && ext_sync)) begin
          nxt_st.fsm = st_release; // [RULE16]
        end
      end
      st_release: begin
        nxt_st.soft_trig = 1'b0; // [RULE7]
        nxt_st.fsm       = st_run;
        nxt_st.cause     = rst_pkg::cause_none;
        nxt_st.quasi     = 1'b1;
        nxt_st.hold_cnt  = '0;
      end
      default: nxt_st.fsm = st_run;
    endcase
    if (st_ff.quasi && slow_osc_tick && st_ff.fsm == st_run) begin
      if (st_ff.hold_cnt == hold_count_w_l'(HOLD_CNT - 1)) begin
        nxt_st.quasi = 1'b0; // [RULE19]
      end else begin
        nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Power-on: both flags cleared, everything else initial
      st_ff          <= '0;
      st_ff.fsm      <= st_run;
      st_ff.cause    <= rst_pkg::cause_none;
      st_ff.wdc_other <= 8'h07;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sys_reset        = (st_ff.fsm != st_run) || !st_ff.por_done; // [RULE1]
  // Blocks the core in the trigger cycle itself
  assign instr_block      = sys_reset || (st_ff.fsm == st_run && st_ff.key_open &&
                            hit(req, rst_pkg::chip_control_addr) &&
                            req.wdata[rst_pkg::soft_trig_bit]); // [RULE6]
  assign boot_from_loader = st_ff.boot_sel; // [RULE11] [RULE14]
  assign rdata            = st_ff.rdata;
  assign debug_pins_quasi = st_ff.quasi || sys_reset; // [RULE19]
  always_comb begin
    core_rst.pc         = rst_pkg::reset_pc; // [RULE16]
    core_rst.sp         = rst_pkg::reset_sp; // [RULE17]
    core_rst.port_latch = rst_pkg::port_latch_reset; // [RULE18]
    core_rst.ram_clear  = 1'b0; // [RULE15]
    core_rst.periph_en  = !sys_reset; // [RULE18]
  end

  ////////////////////////////////////////////////////////////////////////////
  a_wdt_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_wdt) |=> st_ff.wdt_flag) // [RULE3]
    else $error("watchdog flag not set");
  a_wdt_resets: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.por_done && st_ff.fsm == st_run && wdt_expire) |=> sys_reset) // [RULE1]
    else $error("watchdog expiry did not reset");
  a_soft_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_soft) |=> st_ff.soft_flag) // [RULE8]
    else $error("soft flag not set");
  a_soft_keeps_boot: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_soft) |=> $stable(st_ff.boot_sel)) // [RULE12]
    else $error("soft reset changed boot select");
  a_boot_loads_inv: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_assert && st_ff.cause != rst_pkg::cause_soft) |=>
    (st_ff.boot_sel == ~$past(option_word_zero[7]))) // [RULE13]
    else $error("boot select not inverted option");
  a_trig_selfclear: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_release) |=> !st_ff.soft_trig) // [RULE7]
    else $error("trigger not cleared");
  a_soft_trig_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.por_done && st_ff.fsm == st_run && !wdt_expire && st_ff.key_open &&
     hit(req, rst_pkg::chip_control_addr) && req.wdata[7]) |-> instr_block ##1 sys_reset) // [RULE6]
    else $error("instruction after soft trigger");
  a_wdt_flag_kept: assert property (@(posedge mclk) disable iff (!rstn)
    (st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_ext) |=> $stable(st_ff.wdt_flag)) // [RULE4]
    else $error("watchdog flag lost on ext reset");
  a_pc_held: assert property (@(posedge mclk) disable iff (!rstn)
    sys_reset |-> (core_rst.pc == 16'h0000 && core_rst.sp == 8'h07 && !core_rst.periph_en)) // [RULE16]
    else $error("core not held in reset");
  c_wdt_reset: cover property (@(posedge mclk) disable iff (!rstn)
    st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_wdt);
  c_soft_reset: cover property (@(posedge mclk) disable iff (!rstn)
    st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_soft);
  c_ext_reset: cover property (@(posedge mclk) disable iff (!rstn)
    st_ff.fsm == st_assert && st_ff.cause == rst_pkg::cause_ext);
  c_quasi_end: cover property (@(posedge mclk) disable iff (!rstn) $fell(st_ff.quasi));
endmodule // reset_source_and_boot_select

/* reset_source_and_boot_select_test.sv */
`timescale 1ns/1ps
module reset_source_and_boot_select_test;
  logic                 mclk              = 1'b0;
  logic                 rstn              = 1'b0;
  logic                 ext_rst_pin       = 1'b0;
  logic                 slow_osc_tick     = 1'b0;
  logic                 global_irq_enable = 1'b0;
  logic                 tick_en           = 1'b0;
  logic [1:0]           tick_ph           = 2'h0;
  logic [11:0]          wdt_limit         = 12'h040;
  logic [7:0]           option_word_zero  = 8'hff;
  rst_pkg::reg_req_t    req               = '0;
  logic [7:0]           rdata;
  logic                 sys_reset;
  logic                 instr_block;
  logic                 boot_from_loader;
  logic                 debug_pins_quasi;
  rst_pkg::core_reset_t core_rst;
  logic [7:0]           rd_v;
  int                   failures          = 0;
  int                   checks_done       = 0;
  int                   n;

  always #50 mclk = ~mclk;

  // Slow oscillator stand-in: one pulse every four system clocks, gated
  always @(posedge mclk) begin
    tick_ph       <= tick_ph + 2'h1;
    slow_osc_tick <= tick_en && (tick_ph == 2'h3);
  end

  reset_source_and_boot_select #(.HOLD_CNT(4)) reset_source_and_boot_select_i (
    .mclk              (mclk),
    .rstn              (rstn),
    .ext_rst_pin       (ext_rst_pin),
    .slow_osc_tick     (slow_osc_tick),
    .wdt_limit         (wdt_limit),
    .option_word_zero  (option_word_zero),
    .req               (req),
    .global_irq_enable (global_irq_enable),
    .rdata             (rdata),
    .sys_reset         (sys_reset),
    .instr_block       (instr_block),
    .boot_from_loader  (boot_from_loader),
    .core_rst          (core_rst),
    .debug_pins_quasi  (debug_pins_quasi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 rd_v = rdata;
  endtask

  // Key pair then the protected write, as software must do it
  task automatic keyed_wr(input logic [7:0] a, input logic [7:0] d);
    wr_reg(rst_pkg::timed_access_addr, rst_pkg::key_first);
    wr_reg(rst_pkg::timed_access_addr, rst_pkg::key_second);
    wr_reg(a, d);
  endtask

  task automatic wait_rst(input logic lvl, input int bound);
    // Step off the edge so the level seen is the settled one
    #1;
    n = 0;
    while (sys_reset !== lvl && n < bound) begin
      @(posedge mclk);
      #1 n++;
    end
    if (sys_reset !== lvl) begin
      failures++;
      $display("wrong value sys_reset wait expected %h seen %h", lvl, sys_reset);
      close_out();
    end
  endtask

  task automatic check_core();
    check("pc", core_rst.pc, rst_pkg::reset_pc);
    check("sp", core_rst.sp, rst_pkg::reset_sp);
    check("latch", core_rst.port_latch, rst_pkg::port_latch_reset);
    check("periph", core_rst.periph_en, 1'b0);
    check("ram_clear", core_rst.ram_clear, 1'b0);
  endtask

  task automatic ext_pulse();
    ext_rst_pin <= 1'b1;
    wait_rst(1'b1, 8);
    check_core();
    @(posedge mclk);
    ext_rst_pin <= 1'b0;
    wait_rst(1'b0, 12);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    wait_rst(1'b0, 20);
    check("boot_por", boot_from_loader, 1'b0);
    rd_reg(rst_pkg::auxiliary_one_addr);
    check("soft_flag_por", rd_v[7], 1'b0);
    rd_reg(rst_pkg::watchdog_control_addr);
    check("wdt_flag_por", rd_v[3], 1'b0);
    rd_reg(8'h00);
    check("unmapped", rd_v, 8'h00);
    // Trigger without the key must only move the boot bit
    wr_reg(rst_pkg::chip_control_addr, 8'h82);
    repeat (6) @(posedge mclk);
    #1 check("no_key_reset", sys_reset, 1'b0);
    check("boot_sw", boot_from_loader, 1'b1);
    keyed_wr(rst_pkg::chip_control_addr, 8'h82);
    wait_rst(1'b1, 4);
    check("block", instr_block, 1'b1);
    check_core();
    wait_rst(1'b0, 12);
    check("boot_soft", boot_from_loader, 1'b1);
    rd_reg(rst_pkg::auxiliary_one_addr);
    check("soft_flag", rd_v[7], 1'b1);
    rd_reg(rst_pkg::chip_control_addr);
    check("trig_rd", rd_v[7], 1'b0);
    ext_pulse();
    check("boot_ext", boot_from_loader, 1'b0);
    rd_reg(rst_pkg::auxiliary_one_addr);
    check("soft_keep_ext", rd_v[7], 1'b1);
    // Watchdog kept alive by clears, then left to expire
    // Divider stays at 00H and no power-down, so watchdog recovery holds
    wdt_limit <= 12'h003;
    tick_en   <= 1'b1;
    repeat (6) keyed_wr(rst_pkg::watchdog_control_addr, 8'h40);
    #1 check("wdt_cleared", sys_reset, 1'b0);
    option_word_zero <= 8'h7f;
    wait_rst(1'b1, 40);
    check("pc_wdt", core_rst.pc, rst_pkg::reset_pc);
    wdt_limit <= 12'h040;
    wait_rst(1'b0, 12);
    check("quasi_start", debug_pins_quasi, 1'b1);
    repeat (8) @(posedge mclk);
    #1 check("quasi_hold", debug_pins_quasi, 1'b1);
    n = 0;
    while (debug_pins_quasi !== 1'b0 && n < 30) begin
      @(posedge mclk);
      #1 n++;
    end
    check("quasi_end", debug_pins_quasi, 1'b0);
    tick_en <= 1'b0;
    check("boot_wdt", boot_from_loader, 1'b1);
    rd_reg(rst_pkg::watchdog_control_addr);
    check("wdt_flag", rd_v[3], 1'b1);
    rd_reg(rst_pkg::auxiliary_one_addr);
    check("soft_keep_wdt", rd_v[7], 1'b1);
    ext_pulse();
    rd_reg(rst_pkg::watchdog_control_addr);
    check("wdt_keep_ext", rd_v[3], 1'b1);
    keyed_wr(rst_pkg::watchdog_control_addr, 8'h00);
    rd_reg(rst_pkg::watchdog_control_addr);
    check("wdt_clear", rd_v[3], 1'b0);
    wr_reg(rst_pkg::auxiliary_one_addr, 8'h00);
    rd_reg(rst_pkg::auxiliary_one_addr);
    check("soft_clear", rd_v[7], 1'b0);
    close_out();
  end
endmodule // reset_source_and_boot_select_test
